// ---- logic/dscp_port.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - first eight rising edges shift instruction byte
// - data phase moves exactly one byte
// - write lands on last data bit
// - chip select high on byte boundary stalls
// - chip select high mid-byte resets port
// - instruction bit 7 high means read
// - instruction bits 6..0 give register address
// - msb-first and lsb-first both supported
// - one bidirectional pin or separate output
// - every register readable and writable serially
// - sample and launch on rising serial clock
// - chip select high floats both data pins
// - config bit 7 selects pin mode, default 1
// - config bit 6 selects bit order, default 0
module dscp_port (
  // system clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // serial link from the host
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe,
  // device-side view of the registers
  input wire logic [6:0] user_addr,
  output logic [7:0] user_data,
  output logic [7:0] cfg_reg,
  output logic wr_pulse,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [2:0] sync_q;
  logic sclk_q;
  logic cs_n_q;
  logic sdio_q;
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic rise;
  dscp_pkg::dscp_state_t st_r;
  dscp_pkg::dscp_state_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic rd_r;
  logic rd_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic [7:0] out_sh_r;
  logic [7:0] out_sh_nxt;
  logic out_bit_r;
  logic out_bit_nxt;
  logic oe_r;
  logic oe_nxt;
  // the whole map sits in flops: it costs area, but every byte reads in one cycle
  logic [7:0] mem_r [dscp_pkg::REG_COUNT];
  logic [7:0] mem_nxt [dscp_pkg::REG_COUNT];
  logic [7:0] user_data_r;
  logic [7:0] user_data_nxt;
  logic wr_pulse_r;
  logic wr_pulse_nxt;
  logic [6:0] wr_addr_r;
  logic [6:0] wr_addr_nxt;
  logic [7:0] wr_data_r;
  logic [7:0] wr_data_nxt;
  logic lsb_first;
  logic bidir;

  // all link pins pass two flops; clock and data keep the same latency
  // limitation: sclk must stay high and low for longer than one system clock or edges are lost
  dscp_sync i_dscp_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_i({sdio_i, cs_n, sclk}),
    .sync_o(sync_q)
  );

  assign sclk_q = sync_q[0];
  assign cs_n_q = sync_q[1];
  assign sdio_q = sync_q[2];
  assign rise = sclk_q & ~sclk_d_r;
  assign lsb_first = mem_r[dscp_pkg::CFG_ADDR][dscp_pkg::ORDER_BIT];
  assign bidir = mem_r[dscp_pkg::CFG_ADDR][dscp_pkg::DIR_BIT];

  always_comb begin
    logic [7:0] sh_v;
    logic [7:0] byte_v;
    sh_v = dscp_pkg::shift_in(sh_r, sdio_q, lsb_first);
    byte_v = 8'h00;
    sclk_d_nxt = sclk_q;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    out_sh_nxt = out_sh_r;
    out_bit_nxt = out_bit_r;
    mem_nxt = mem_r;
    wr_pulse_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (cs_n_q) begin
      // a stall off a byte boundary, or the end of a cycle, restarts the port
      if (cnt_r != 3'h0 || st_r == dscp_pkg::ST_DONE) begin
        st_nxt = dscp_pkg::ST_INSTR;
        cnt_nxt = 3'h0;
      end else begin
        // on a byte boundary state is held and shifting resumes later
        st_nxt = st_r;
        cnt_nxt = cnt_r;
      end
    end else if (rise) begin
      case (st_r)
        dscp_pkg::ST_INSTR: begin
          sh_nxt = sh_v;
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_r == dscp_pkg::LAST_BIT) begin
            rd_nxt = sh_v[dscp_pkg::RW_BIT];
            addr_nxt = sh_v[6:0];
            st_nxt = dscp_pkg::ST_DATA;
            // read data is taken here, so a later write cannot tear a byte in flight
            byte_v = mem_r[sh_v[6:0]];
            out_sh_nxt = byte_v;
            out_bit_nxt = dscp_pkg::head_bit(byte_v, lsb_first);
          end
        end
        dscp_pkg::ST_DATA: begin
          sh_nxt = sh_v;
          cnt_nxt = cnt_r + 3'h1;
          if (rd_r) begin
            // next bit launched on this rising edge
            byte_v = lsb_first ? {1'b0, out_sh_r[7:1]} : {out_sh_r[6:0], 1'b0};
            out_sh_nxt = byte_v;
            out_bit_nxt = dscp_pkg::head_bit(byte_v, lsb_first);
          end
          if (cnt_r == dscp_pkg::LAST_BIT) begin
            st_nxt = dscp_pkg::ST_DONE;
            if (!rd_r) begin
              mem_nxt[addr_r] = sh_v;
              wr_pulse_nxt = 1'b1;
              wr_addr_nxt = addr_r;
              wr_data_nxt = sh_v;
              if (addr_r == dscp_pkg::CFG_ADDR && sh_v[dscp_pkg::SRST_BIT]) begin
                // soft reset restores all but the config register, and self-clears
                for (int i = 1; i < dscp_pkg::REG_COUNT; i++) begin
                  mem_nxt[i] = dscp_pkg::REG_RST;
                end
                mem_nxt[dscp_pkg::CFG_ADDR][dscp_pkg::SRST_BIT] = 1'b0;
              end
            end
          end
        end
        dscp_pkg::ST_DONE: begin
          // extra edges after the single data byte are ignored
          cnt_nxt = cnt_r;
        end
        default: begin
          st_nxt = dscp_pkg::ST_INSTR;
          cnt_nxt = 3'h0;
        end
      endcase
    end
    // drive only during a read data phase with chip select low
    // both pins float otherwise, so a host still driving the line never contends
    oe_nxt = ~cs_n_q & rd_nxt & (st_nxt == dscp_pkg::ST_DATA);
    // the device view follows the next state, so a landing write shows at once
    user_data_nxt = mem_nxt[user_addr];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_r <= 1'b0;
      st_r <= dscp_pkg::ST_INSTR;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      addr_r <= 7'h00;
      out_sh_r <= 8'h00;
      out_bit_r <= 1'b0;
      oe_r <= 1'b0;
      user_data_r <= 8'h00;
      wr_pulse_r <= 1'b0;
      wr_addr_r <= 7'h00;
      wr_data_r <= 8'h00;
      for (int i = 0; i < dscp_pkg::REG_COUNT; i++) begin
        mem_r[i] <= (i == 0) ? dscp_pkg::CFG_RST : dscp_pkg::REG_RST;
      end
    end else begin
      sclk_d_r <= sclk_d_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      out_sh_r <= out_sh_nxt;
      out_bit_r <= out_bit_nxt;
      oe_r <= oe_nxt;
      user_data_r <= user_data_nxt;
      wr_pulse_r <= wr_pulse_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      for (int i = 0; i < dscp_pkg::REG_COUNT; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  // pin mode picks which pin carries read data; the other stays floating
  assign sdio_o = out_bit_r;
  assign sdio_oe = oe_r & bidir;
  assign serial_data_out_pin_o = out_bit_r;
  assign serial_data_out_pin_oe = oe_r & ~bidir;
  assign user_data = user_data_r;
  assign cfg_reg = mem_r[dscp_pkg::CFG_ADDR];
  assign wr_pulse = wr_pulse_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;
endmodule

// ---- logic/dscp_pkg.sv ----
package dscp_pkg;
  // sizes of the serial frame
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_COUNT = 128;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // instruction byte layout
  localparam int unsigned RW_BIT = 7;
  // port configuration register and its fields
  localparam logic [6:0] CFG_ADDR = 7'h00;
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned ORDER_BIT = 6;
  localparam int unsigned SRST_BIT = 5;
  // values after reset
  localparam logic [7:0] CFG_RST = 8'h80;
  localparam logic [7:0] REG_RST = 8'h00;
  // timing: the link clock is sampled by the system clock
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SCLK_MAX_HZ = 20_000_000;
  localparam int unsigned SCLK_MIN_HALF_CYC = (CLK_HZ / SCLK_MAX_HZ) / 2;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b10
  } dscp_state_t;

  // shift one received bit into a byte in the selected order
  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b,
                                          input logic lsb_first);
    if (lsb_first) begin
      shift_in = {b, cur[7:1]};
    end else begin
      shift_in = {cur[6:0], b};
    end
  endfunction

  // the bit to present next from a byte being sent
  function automatic logic head_bit(input logic [7:0] cur, input logic lsb_first);
    head_bit = lsb_first ? cur[0] : cur[7];
  endfunction
endpackage

// ---- logic/dscp_sync.sv ----
`timescale 1ns/1ns
module dscp_sync (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // asynchronous levels in
  input wire logic [2:0] async_i,
  // synchronised levels out
  output logic [2:0] sync_o
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] meta_nxt;
  logic [2:0] sync_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // cs_n idles high, so it resets to the inactive level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 3'h2;
      sync_r <= 3'h2;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule

// ---- testbench/dscp_port_monitor.sv ----
`timescale 1ns/1ns
module dscp_port_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // serial side
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic serial_data_out_pin_oe,
  // register side
  input wire logic [6:0] user_addr,
  input wire logic [7:0] user_data,
  input wire logic [7:0] cfg_reg,
  input wire logic wr_pulse,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_float; cs_n [*5] |-> !sdio_oe && !serial_data_out_pin_oe; endproperty
  a_float: assert property (p_float) else $error("pin driven");
  property p_one; !(sdio_oe && serial_data_out_pin_oe); endproperty
  a_one: assert property (p_one) else $error("both pins");
  // chip select reaches the enable through two sync flops and one register
  property p_dir; sdio_oe |-> cfg_reg[7] && $past(!cs_n, 3); endproperty
  a_dir: assert property (p_dir) else $error("pin mode");
  property p_launch; $changed(sdio_o) |-> $past(sclk); endproperty
  a_launch: assert property (p_launch) else $error("launch");
  property p_once; wr_pulse |=> !wr_pulse [*8]; endproperty
  a_once: assert property (p_once) else $error("double write");
  property p_idle; cs_n [*6] |-> !wr_pulse; endproperty
  a_idle: assert property (p_idle) else $error("write unselected");
  property p_land; wr_pulse && wr_addr != 7'h00 && user_addr == wr_addr
    |-> ##[1:2] user_data == wr_data; endproperty
  a_land: assert property (p_land) else $error("write lost");
  property p_cfg; wr_pulse && wr_addr == 7'h00 |-> ##[0:1] cfg_reg == (wr_data & 8'hdf);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config lost");
  c_cfg: cover property (wr_pulse && wr_addr == 7'h00);
  c_bidir: cover property ($rose(sdio_oe));
  c_sep: cover property ($rose(serial_data_out_pin_oe));
endmodule
bind dscp_port dscp_port_monitor i_dscp_port_monitor (.*);

// ---- testbench/dscp_host.sv ----
`timescale 1ns/1ns
module dscp_host (
  // system clock, paces the host
  input wire logic clock,
  // link to the device
  output logic sclk,
  output logic cs_n,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic so_o,
  input wire logic so_oe
);
  logic hbit = 1'h0;
  logic drv = 1'h1;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
  end
  // a released line shows the inverse of the last bit, never a kept value
  assign sdio_i = sdio_oe ? sdio_o : (drv ? hbit : ~hbit);
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic shift(input int n, input logic [7:0] v, input logic lsb, input logic d,
                       output logic [7:0] r);
    drv = d;
    for (int i = 0; i < n; i++) begin
      hbit = lsb ? v[i] : v[7 - i];
      wait_clk(4);
      r[lsb ? i : 7 - i] = sdio_oe ? sdio_o : (so_oe ? so_o : 1'bx);
      sclk = 1'h1;
      wait_clk(4);
      sclk = 1'h0;
    end
  endtask
  task automatic frame(input logic [7:0] ins, input logic [7:0] dat, input logic lsb,
                       input logic stall, output logic [7:0] rd);
    logic [7:0] junk;
    cs_n = 1'h0;
    wait_clk(2);
    shift(8, ins, lsb, 1'h1, junk);
    if (stall) begin
      cs_n = 1'h1;
      wait_clk(8);
      cs_n = 1'h0;
      wait_clk(2);
    end
    shift(8, dat, lsb, !ins[7], rd);
    wait_clk(2);
    cs_n = 1'h1;
    drv = 1'h1;
    wait_clk(6);
  endtask
  task automatic partial(input int n);
    logic [7:0] junk;
    cs_n = 1'h0;
    wait_clk(2);
    shift(n, 8'hff, 1'h0, 1'h1, junk);
    cs_n = 1'h1;
    wait_clk(6);
  endtask
endmodule

// ---- testbench/dscp_port_test.sv ----
`timescale 1ns/1ns
module dscp_port_test;
  logic clock, arst_n, sclk, cs_n, sdio_i, sdio_o, sdio_oe, so_o, so_oe, wr_pulse;
  logic [6:0] user_addr, wr_addr;
  logic [7:0] user_data, cfg_reg, wr_data, rd;
  int err_count = 0;
  int checks_done = 0;
  dscp_port i_dscp_port (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_data_out_pin_o(so_o),
    .serial_data_out_pin_oe(so_oe), .user_addr(user_addr), .user_data(user_data),
    .cfg_reg(cfg_reg), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data));
  dscp_host i_dscp_host (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .so_o(so_o), .so_oe(so_oe));
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // write, then read back both over the link and through the device-side view
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, input logic lsb,
                       input logic stall);
    user_addr = a;
    i_dscp_host.frame({1'h0, a}, d, lsb, stall, rd);
    check({1'h0, wr_addr}, {1'h0, a});
    check(wr_data, d);
    check(user_data, d);
    i_dscp_host.frame({1'h1, a}, 8'h00, lsb, stall, rd);
    check(rd, d);
  endtask
  task automatic test_reset;
    check(cfg_reg, dscp_pkg::CFG_RST);
    check(user_data, dscp_pkg::REG_RST);
    check({6'h00, sdio_oe, so_oe}, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_basic;
    wr_rd(7'h2a, 8'ha5, 1'h0, 1'h0);
    wr_rd(7'h7f, 8'h3c, 1'h0, 1'h0);
    $display("test basic done");
  endtask
  task automatic test_stall;
    wr_rd(7'h11, 8'h5a, 1'h0, 1'h1);
    $display("test stall done");
  endtask
  // a cut byte must write nothing, and the next cycle must start clean
  task automatic test_abort;
    i_dscp_host.partial(5);
    check({1'h0, wr_addr}, 8'h11);
    wr_rd(7'h22, 8'h99, 1'h0, 1'h0);
    $display("test abort done");
  endtask
  task automatic test_lsb_sep;
    i_dscp_host.frame(8'h00, 8'h40, 1'h0, 1'h0, rd);
    check(cfg_reg, 8'h40);
    wr_rd(7'h33, 8'hc1, 1'h1, 1'h1);
    $display("test lsb separate pin done");
  endtask
  // soft reset clears 0x33 but keeps the config byte, with its reset bit cleared
  task automatic test_soft_reset;
    i_dscp_host.frame(8'h00, 8'h60, 1'h1, 1'h0, rd);
    check(cfg_reg, 8'h40);
    check(user_data, dscp_pkg::REG_RST);
    $display("test soft reset done");
  endtask
  initial begin
    arst_n = 1'h0;
    user_addr = 7'h05;
    repeat (4) @(posedge clock);
    #2 arst_n = 1'h1;
    repeat (3) @(posedge clock);
    #2;
    test_reset;
    test_basic;
    test_stall;
    test_abort;
    test_lsb_sep;
    test_soft_reset;
    print_verdict;
  end
  // a hang cuts the run short, after about 50,000 clocks
  initial begin
    #1000000;
    err_count++;
    print_verdict;
  end
endmodule
